// File: src/tlrc_ctrl.sv
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "tlrc_defs.svh"
module tlrc_ctrl #(
  parameter int DW = 10
) (
  // Clock and reset
  input  wire  logic          aclk,
  input  wire  logic          aresetn,
  // AXI4-Lite write address
  input  wire  logic [11:0]   s_axi_awaddr,
  input  wire  logic          s_axi_awvalid,
  output logic                s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [31:0]   s_axi_wdata,
  input  wire  logic [3:0]    s_axi_wstrb,
  input  wire  logic          s_axi_wvalid,
  output logic                s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire  logic          s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [11:0]   s_axi_araddr,
  input  wire  logic          s_axi_arvalid,
  output logic                s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire  logic          s_axi_rready,
  // Receive side: rate matcher output words
  input  wire  logic [DW-1:0] rm_data,
  input  wire  logic          rm_valid,
  // Normal transmit path words
  input  wire  logic [DW-1:0] tx_norm_data,
  input  wire  logic          tx_norm_valid,
  // Serializer input
  output logic [DW-1:0]       ser_data,
  output logic                ser_valid,
  // Receive continuation toward decoder
  output logic [DW-1:0]       dec_data,
  output logic                dec_valid,
  // Per-channel resets and block power
  output logic                tx_digital_rst,
  output logic                rx_analog_rst,
  output logic                rx_digital_rst,
  output logic                blk_powerdown,
  output logic                blk_enable,
  // Loopback active indicator
  output logic                lpbk_active
);

  // Software registers
  // Only the low bits of each are implemented
  logic [31:0]      ctrl_reg;    // Request, PIPE mode, power state
  logic [31:0]      rst_reg;     // Reset bits
  logic [31:0]      pwr_reg;     // Power bits
  // Bus handshake state
  // Each channel holds its beat until the response is taken
  logic             aw_held_reg; // Write address captured
  logic             w_held_reg;  // Write data captured
  logic [11:0]      awaddr_reg;  // Captured write address
  logic [31:0]      wdata_reg;   // Captured write data
  logic [3:0]       wstrb_reg;   // Captured strobes
  // Datapath state
  // Source and indicator share one process so they never disagree
  tlrc_pkg::tlrc_src_t src_reg;  // Serializer source
  logic             lpbk_next;   // Loopback condition

  // Loopback condition: request, PIPE mode and full power
  // Dropping any one term ends loopback
  always_comb begin
    lpbk_next = ctrl_reg[`TLRC_CTRL_LPBK] &
                ctrl_reg[`TLRC_CTRL_PIPE] &
                (ctrl_reg[`TLRC_CTRL_PST_HI:`TLRC_CTRL_PST_LO] == `TLRC_PST_P0);
  end

  // Byte-lane merge of a register with write data
  // Lanes without a strobe keep their old byte
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write address channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      // Address handshake: hold it until answered
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      // Response taken: slot is free again
      aw_held_reg <= 1'b0;
    end
  end

  // Write data channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      // Data handshake: hold it until answered
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      // Response taken: slot is free again
      w_held_reg <= 1'b0;
    end
  end

  // Ready while the channel has nothing captured
  // Ready drops in the handshake cycle so no beat is taken twice
  // and stays low while a response waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // No request taken during reset
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Register write and write response
  // Registers change only when both channels are captured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Power-up register values
      ctrl_reg     <= `TLRC_CTRL_RST;
      rst_reg      <= `TLRC_RESET_RST;
      pwr_reg      <= `TLRC_POWER_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TLRC_RESP_OKAY;
    end else if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
      // Both halves captured: commit and answer
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= `TLRC_RESP_OKAY;
      // Decode the captured address
      case (awaddr_reg)
        `TLRC_CTRL_OFF: begin
          // Only request, mode and power state bits are kept
          ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_000f;
        end
        `TLRC_RESET_OFF: begin
          // Three channel reset bits
          rst_reg <= merge(rst_reg, wdata_reg, wstrb_reg) & 32'h0000_0007;
        end
        `TLRC_POWER_OFF: begin
          // Block powerdown and enable bits
          pwr_reg <= merge(pwr_reg, wdata_reg, wstrb_reg) & 32'h0000_0003;
        end
        default: begin
          // Unmapped offset: error, nothing written
          s_axi_bresp <= `TLRC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      // Response taken: free the response slot
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  // Unused bits and unmapped offsets read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TLRC_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      // Answer outstanding: refuse new addresses
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      // Address taken: data stands from the next edge
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `TLRC_RESP_OKAY;
      // Decode read address
      case (s_axi_araddr)
        `TLRC_CTRL_OFF: begin
          s_axi_rdata <= ctrl_reg;                      // Control word
        end
        `TLRC_RESET_OFF: begin
          s_axi_rdata <= rst_reg;                       // Channel resets
        end
        `TLRC_POWER_OFF: begin
          s_axi_rdata <= pwr_reg;                       // Block power
        end
        `TLRC_STATUS_OFF: begin
          s_axi_rdata <= {31'h0000_0000, lpbk_active};  // Loopback indicator
        end
        default: begin
          // Unmapped offset: zero data, error response
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TLRC_RESP_SLVERR;
        end
      endcase
    end else begin
      // Idle: offer the address slot
      s_axi_arready <= 1'b1;
    end
  end

  // Reset and power outputs, each independent
  // Channel resets come up asserted until software clears them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Safe state: channel held, block powered
      tx_digital_rst <= 1'b1;
      rx_analog_rst  <= 1'b1;
      rx_digital_rst <= 1'b1;
      blk_powerdown  <= 1'b0;
      blk_enable     <= 1'b1;
    end else begin
      // Each output follows its own register bit
      tx_digital_rst <= rst_reg[`TLRC_RST_TXD];
      rx_analog_rst  <= rst_reg[`TLRC_RST_RXA];
      rx_digital_rst <= rst_reg[`TLRC_RST_RXD];
      blk_powerdown  <= pwr_reg[`TLRC_PWR_DOWN];
      blk_enable     <= pwr_reg[`TLRC_PWR_EN];
    end
  end

  // Serializer source select; leaves loopback when condition drops
  // Transmit reset bit forces the normal source at once
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_reg[`TLRC_RST_TXD]) begin
      src_reg     <= tlrc_pkg::TLRC_SRC_NORMAL;
      lpbk_active <= 1'b0;
    end else begin
      // Track the loopback condition one cycle later
      src_reg     <= lpbk_next ? tlrc_pkg::TLRC_SRC_LOOP : tlrc_pkg::TLRC_SRC_NORMAL;
      lpbk_active <= lpbk_next;
    end
  end

  // Serializer input mux: rate matcher words replace transmit data
  // Held idle while the transmit digital reset stands
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_digital_rst) begin
      // Idle serializer input
      ser_data  <= '0;
      ser_valid <= 1'b0;
    end else begin
      case (src_reg)
        tlrc_pkg::TLRC_SRC_LOOP: begin
          // Looped receive word
          ser_data  <= rm_data;
          ser_valid <= rm_valid;
        end
        default: begin
          // Normal transmit word
          ser_data  <= tx_norm_data;
          ser_valid <= tx_norm_valid;
        end
      endcase
    end
  end

  // Receive words continue to decoder regardless of loopback
  // Held clear while the receive digital reset stands
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_digital_rst) begin
      // Cleared receive stage
      dec_data  <= '0;
      dec_valid <= 1'b0;
    end else begin
      // Same word also feeds the decoder
      dec_data  <= rm_data;
      dec_valid <= rm_valid;
    end
  end

endmodule

// File: common/tlrc_defs.svh
`ifndef TLRC_DEFS_SVH
`define TLRC_DEFS_SVH
// Register byte offsets
`define TLRC_CTRL_OFF     12'h000
`define TLRC_RESET_OFF    12'h004
`define TLRC_POWER_OFF    12'h008
`define TLRC_STATUS_OFF   12'h00c
// Control register field positions
`define TLRC_CTRL_LPBK    0
`define TLRC_CTRL_PIPE    1
`define TLRC_CTRL_PST_LO  2
`define TLRC_CTRL_PST_HI  3
// Reset register field positions
`define TLRC_RST_TXD      0
`define TLRC_RST_RXA      1
`define TLRC_RST_RXD      2
// Power register field positions
`define TLRC_PWR_DOWN     0
`define TLRC_PWR_EN       1
// Reset values
`define TLRC_CTRL_RST     32'h0000_0000
`define TLRC_RESET_RST    32'h0000_0007
`define TLRC_POWER_RST    32'h0000_0002
// Power state encoding for the full power state
`define TLRC_PST_P0       2'h0
// AXI responses
`define TLRC_RESP_OKAY    2'h0
`define TLRC_RESP_SLVERR  2'h2
`endif

// File: common/tlrc_pkg.sv
package tlrc_pkg;
  // Transmit source selection
  typedef enum logic [1:0] {
    TLRC_SRC_NORMAL = 2'h1,
    TLRC_SRC_LOOP   = 2'h2
  } tlrc_src_t;
endpackage

// File: bench/tlrc_far_model.sv
`timescale 1ns/1ps
module tlrc_far_model #(
  parameter int DW = 10
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Recovered and normal words
  output logic [DW-1:0]      rm_data,
  output logic               rm_valid,
  output logic [DW-1:0]      tx_norm_data,
  output logic               tx_norm_valid
);
  logic [DW:0] cnt_reg; // Pattern counter
  // New receive word each cycle, so a stale copy never matches; normal word every second cycle
  always_ff @(posedge aclk) begin
    cnt_reg <= aresetn ? cnt_reg + 1'b1 : '0;
  end
  assign rm_data       = cnt_reg[DW-1:0];
  assign rm_valid      = cnt_reg[0] ^ cnt_reg[1];
  assign tx_norm_data  = ~cnt_reg[DW:1];
  assign tx_norm_valid = ~cnt_reg[0];
endmodule

// File: bench/tlrc_ctrl_sva.sv
`timescale 1ns/1ps
module tlrc_ctrl_chk #(
  parameter int DW = 10
) (
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Bus handshakes
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  // Datapath and control
  input wire logic [DW-1:0] rm_data,
  input wire logic          rm_valid,
  input wire logic [DW-1:0] tx_norm_data,
  input wire logic [DW-1:0] ser_data,
  input wire logic          ser_valid,
  input wire logic [DW-1:0] dec_data,
  input wire logic          tx_digital_rst,
  input wire logic          rx_digital_rst,
  input wire logic          lpbk_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_loop_data: assert property (
    lpbk_active && $past(lpbk_active) && !tx_digital_rst && !$past(tx_digital_rst)
    |-> {ser_valid, ser_data} == {$past(rm_valid), $past(rm_data)}) else $error("looped word wrong");
  chk_norm_data: assert property (
    !lpbk_active && !$past(lpbk_active) && !tx_digital_rst && !$past(tx_digital_rst)
    |-> ser_data == $past(tx_norm_data)) else $error("normal word wrong");
  chk_dec_follow: assert property (
    !rx_digital_rst && !$past(rx_digital_rst) |-> dec_data == $past(rm_data)) else $error("receive word wrong");
  chk_tx_clear: assert property (
    tx_digital_rst && $past(tx_digital_rst) |-> !ser_valid && ser_data == '0) else $error("tx not cleared");
  chk_rx_clear: assert property (
    rx_digital_rst [*2] |-> dec_data == '0) else $error("rx not cleared");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rvalid)) else $error("rvalid dropped");
  chk_r_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule
bind tlrc_ctrl tlrc_ctrl_chk #(.DW(DW)) i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .rm_data(rm_data), .rm_valid(rm_valid),
  .tx_norm_data(tx_norm_data), .ser_data(ser_data), .ser_valid(ser_valid), .dec_data(dec_data),
  .tx_digital_rst(tx_digital_rst), .rx_digital_rst(rx_digital_rst), .lpbk_active(lpbk_active));

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "tlrc_defs.svh"
module tb_top;
  logic aclk = 0, aresetn = 0;  // Clock and reset
  logic [11:0] awa = 0, ara = 0; // Bus addresses
  logic [31:0] wd = 0, rd, d;   // Bus data
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr, bv, arr, rv;
  logic [1:0] br, rr, r;        // Responses
  logic lpbk, txr, rxar, rxdr, pd, en;
  logic [9:0] rmd, txd;         // Far-side words
  logic rmv, txv;
  logic [9:0] serd, decd, rmd_q, txd_q; // Design words, far words one edge back
  logic sv, dv, rmv_q, txv_q;
  int errors = 0, checked = 0, cyc = 0;
  logic [7:0] rows [9] = '{8'h13, 8'h01, 8'h02, 8'h07, 8'h0b, 8'h0f, 8'h13, 8'h07, 8'h00}; // Expect, control
  always #4 aclk = ~aclk;
  tlrc_far_model #(.DW(10)) i_far (.aclk(aclk), .aresetn(aresetn), .rm_data(rmd), .rm_valid(rmv),
    .tx_norm_data(txd), .tx_norm_valid(txv));
  tlrc_ctrl #(.DW(10)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .rm_data(rmd), .rm_valid(rmv), .tx_norm_data(txd), .tx_norm_valid(txv), .ser_data(serd), .ser_valid(sv),
    .dec_data(decd), .dec_valid(dv), .tx_digital_rst(txr), .rx_analog_rst(rxar), .rx_digital_rst(rxdr),
    .blk_powerdown(pd), .blk_enable(en), .lpbk_active(lpbk));
  // Far-side words as sampled one edge earlier
  always @(posedge aclk) begin
    rmd_q <= rmd;
    rmv_q <= rmv;
    txd_q <= txd;
    txv_q <= txv;
  end
  // Counts and verdict
  task automatic stop_test();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus write, both channels offered together
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    logic ad = 0, dd = 0;
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awr && !ad) begin
        ad = 1;
        awv <= 0;
      end
      if (wr && !dd) begin
        dd = 1;
        wv <= 0;
      end
    end
    while (!bv) @(posedge aclk);
    bry <= 1;
    @(posedge aclk);
    r = br;
    bry <= 0;
    @(posedge aclk);
  endtask
  // Bus read
  task automatic rd_reg(input logic [11:0] a);
    ara <= a;
    arv <= 1;
    do @(posedge aclk); while (!arr);
    arv <= 0;
    while (!rv) @(posedge aclk);
    rry <= 1;
    @(posedge aclk);
    d = rd;
    r = rr;
    rry <= 0;
    @(posedge aclk);
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    // Row loop: loopback request, mode and power state
    wr_reg(`TLRC_RESET_OFF, 32'h0);
    for (int i = 0; i < 9; i++) begin
      wr_reg(`TLRC_CTRL_OFF, {28'h0, rows[i][3:0]});
      chk(lpbk, rows[i][4]);
      rd_reg(`TLRC_STATUS_OFF);
      chk(d, {31'h0, rows[i][4]});
    end
    $display("done: loopback rows");
    // Each channel reset alone
    for (int i = 0; i < 3; i++) begin
      wr_reg(`TLRC_RESET_OFF, 32'h1 << i);
      chk({rxdr, rxar, txr}, 32'h1 << i);
      if (i == 0) chk({sv, serd}, 32'h0);
      if (i == 2) chk({dv, decd}, 32'h0);
    end
    wr_reg(`TLRC_POWER_OFF, 32'h1);
    chk({pd, en}, 32'h2);
    // Power restored before the links carry data
    wr_reg(`TLRC_POWER_OFF, `TLRC_POWER_RST);
    chk({pd, en}, 32'h1);
    $display("done: resets and power");
    // Unmapped place
    wr_reg(12'h100, 32'hffff_ffff);
    chk(r, `TLRC_RESP_SLVERR);
    rd_reg(12'h100);
    chk({r, d[29:0]}, {`TLRC_RESP_SLVERR, 30'h0});
    $display("done: unmapped");
    // Datapath normal then looped, then reset in mid-run while looping
    wr_reg(`TLRC_RESET_OFF, 32'h0);
    repeat (4) begin
      chk({sv, serd}, {txv_q, txd_q});
      chk({dv, decd}, {rmv_q, rmd_q});
      @(posedge aclk);
    end
    wr_reg(`TLRC_CTRL_OFF, 32'h3);
    repeat (4) begin
      chk({sv, serd}, {rmv_q, rmd_q});
      chk({dv, decd}, {rmv_q, rmd_q});
      @(posedge aclk);
    end
    $display("done: datapath");
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    chk({lpbk, txr, rxar, rxdr, pd, en}, 32'h1d);
    aresetn <= 1;
    @(posedge aclk);
    rd_reg(`TLRC_RESET_OFF);
    chk(d, `TLRC_RESET_RST);
    rd_reg(`TLRC_POWER_OFF);
    chk(d, `TLRC_POWER_RST);
    $display("done: mid-run reset");
    stop_test();
  end
endmodule
